//--- verilog/irq_prio_defs.svh
`ifndef IRQ_PRIO_DEFS_SVH
`define IRQ_PRIO_DEFS_SVH

// reset values of the priority registers
`define PRIO_A_RST 16'h0000
`define PRIO_B_RST 16'h0000
`define PRIO_C_RST 16'h0000
`define PRIO_D_RST 16'hda74
`define PRIO_EXT_RST 16'h0000

// writable bits of register b; bits 3-0 are reserved and read as zero
`define PRIO_B_MASK 16'hfff0

// nibble index of each 4-bit level field: 3 = bits 15-12 ... 0 = bits 3-0
`define FLD_15_12 3
`define FLD_11_8 2
`define FLD_7_4 1
`define FLD_3_0 0

// levels
`define LVL_NMI 5'h10
`define LVL_NONE 5'h00
`define PIN_IDLE 4'hf

// event codes
`define EV_NMI 12'h1c0
`define EV_PIN_BASE 12'h200
`define EV_PIN0 12'h240
`define EV_PIN1 12'h2a0
`define EV_PIN2 12'h300
`define EV_PIN3 12'h360
`define EV_DEBUG 12'h600
`define EV_PORT 12'h620
`define EV_DMA0 12'h640
`define EV_DMA1 12'h660
`define EV_DMA2 12'h680
`define EV_DMA3 12'h6a0
`define EV_DMA4 12'h780
`define EV_DMA5 12'h7a0
`define EV_DMA6 12'h7c0
`define EV_DMA7 12'h7e0
`define EV_DMA_FAULT 12'h6c0
`define EV_TMR3 12'hb00
`define EV_TMR4 12'hb80
`define EV_TMR0 12'h400
`define EV_TMR1 12'h420
`define EV_TMR2 12'h440
`define EV_TMR2_CAP 12'h460
`define EV_ALARM 12'h480
`define EV_PERIODIC 12'h4a0
`define EV_CARRY 12'h4c0
`define EV_SCI_RX_ERR 12'h4e0
`define EV_SCI_RX_FULL 12'h500
`define EV_SCI_TX_EMPTY 12'h520
`define EV_SCI_TX_END 12'h540
`define EV_FIFO_SERIAL_UNIT_RX_ERR 12'h700
`define EV_FIFO_SERIAL_UNIT_RX_FULL 12'h720
`define EV_FIFO_SERIAL_UNIT_BREAK 12'h740
`define EV_FIFO_SERIAL_UNIT_TX_EMPTY 12'h760
`define EV_INTERVAL 12'h560
`define EV_REFRESH_MATCH 12'h580
`define EV_REFRESH_OVF 12'h5a0

`endif

//--- verilog/irq_prio_pkg.sv
package irq_prio_pkg;

   // selects which priority register a write lands in
   typedef enum logic [2:0] {
      SEL_A,
      SEL_B,
      SEL_C,
      SEL_D,
      SEL_EXT
   } prio_sel_t;

   // request lines from the on-chip units, all active high levels
   typedef struct packed {
      logic debug_iface;
      logic port_irq;
      logic [7:0] dma_done_irq;
      logic dma_addr_fault_irq;
      logic [4:0] timer_underflow_irq;
      logic timer_capture_irq;
      logic alarm_irq;
      logic periodic_irq;
      logic carry_irq;
      logic sci_rx_error_irq;
      logic sci_rx_full_irq;
      logic sci_tx_empty_irq;
      logic sci_tx_end_irq;
      logic fifo_serial_unit_rx_error_irq;
      logic fifo_serial_unit_rx_full_irq;
      logic fifo_serial_unit_line_break_irq;
      logic fifo_serial_unit_tx_empty_irq;
      logic interval_irq;
      logic refresh_match_irq;
      logic refresh_overflow_irq;
   } periph_irq_t;

   // the request offered to the cpu
   typedef struct packed {
      logic pending;
      logic [4:0] level;
      logic [11:0] code;
   } irq_result_t;

endpackage

//--- verilog/level_pick.sv
`timescale 1ns/100ps
`default_nettype none

// picks the entry with the highest nonzero level; on a tie the lowest
// index wins, so the entry order is the default tie-break order
module level_pick #(
   parameter int N = 37,
   parameter int LW = 5,
   parameter int CW = 12
) (
   input wire logic [N-1:0][LW-1:0] lvl_i,
   input wire logic [N-1:0][CW-1:0] code_i,
   output logic valid_o,
   output logic [LW-1:0] lvl_o,
   output logic [CW-1:0] code_o
);

   // linear scan: strict greater-than keeps the earlier entry on ties
   always_comb begin
      lvl_o = '0;
      code_o = '0;
      for (int i = 0; i < N; i++) begin
         if (lvl_i[i] > lvl_o) begin
            lvl_o = lvl_i[i];
            code_o = code_i[i];
         end
      end
      valid_o = (lvl_o != '0);
   end

endmodule

`default_nettype wire

//--- verilog/interrupt_priority_resolver.sv
`timescale 1ns/100ps
`default_nettype none
`include "irq_prio_defs.svh"

module interrupt_priority_resolver #(
   parameter bit BASE_VARIANT = 1'b0,
   parameter int NSRC = 37
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic nmi_req_i,
   input wire logic [3:0] encoded_request_pins_n_i,
   input wire logic pin_mode_select_i,
   input wire irq_prio_pkg::periph_irq_t periph_irq_i,
   input wire logic prio_wr_i,
   input wire irq_prio_pkg::prio_sel_t prio_sel_i,
   input wire logic [15:0] prio_wdata_i,
   output logic [15:0] priority_reg_a_o,
   output logic [15:0] priority_reg_b_o,
   output logic [15:0] priority_reg_c_o,
   output logic [15:0] priority_reg_d_o,
   output logic [15:0] extended_priority_reg_o,
   output irq_prio_pkg::irq_result_t result_o
);

   logic [15:0] prio_a_q, prio_a_d;
   logic [15:0] prio_b_q, prio_b_d;
   logic [15:0] prio_c_q, prio_c_d;
   logic [15:0] prio_d_q, prio_d_d;
   logic [15:0] prio_ext_q, prio_ext_d;
   logic [3:0] pin_meta_q, pin_sync_q;
   irq_prio_pkg::irq_result_t result_q, result_d;
   logic [NSRC-1:0][4:0] src_lvl;
   logic [NSRC-1:0][11:0] src_code;
   logic pick_valid;
   logic [4:0] pick_lvl;
   logic [11:0] pick_code;

   // one 4-bit level field of a priority register, widened to a level
   function automatic logic [4:0] fld(input logic [15:0] r, input int idx);
      fld = {1'b0, r[idx*4 +: 4]};
   endfunction

   // a request counts only at a nonzero level
   function automatic logic [4:0] ent(input logic req, input logic [4:0] lvl);
      ent = req ? lvl : `LVL_NONE;
   endfunction

   // codes in default order; entry 1 is the encoded pin code, filled live
   localparam logic [NSRC-1:0][11:0] CODES = {
      `EV_REFRESH_OVF, `EV_REFRESH_MATCH, `EV_INTERVAL,
      `EV_FIFO_SERIAL_UNIT_TX_EMPTY, `EV_FIFO_SERIAL_UNIT_BREAK, `EV_FIFO_SERIAL_UNIT_RX_FULL, `EV_FIFO_SERIAL_UNIT_RX_ERR,
      `EV_SCI_TX_END, `EV_SCI_TX_EMPTY, `EV_SCI_RX_FULL, `EV_SCI_RX_ERR,
      `EV_CARRY, `EV_PERIODIC, `EV_ALARM,
      `EV_TMR2_CAP, `EV_TMR2, `EV_TMR1, `EV_TMR0, `EV_TMR4, `EV_TMR3,
      `EV_DMA_FAULT, `EV_DMA7, `EV_DMA6, `EV_DMA5, `EV_DMA4,
      `EV_DMA3, `EV_DMA2, `EV_DMA1, `EV_DMA0,
      `EV_PORT, `EV_DEBUG,
      `EV_PIN3, `EV_PIN2, `EV_PIN1, `EV_PIN0,
      `EV_PIN_BASE, `EV_NMI
   };

   // register writes; the cpu block bit discipline is software's job,
   // so a write here takes effect on the next edge whatever the cpu state
   always_comb begin
      prio_a_d = prio_a_q;
      prio_b_d = prio_b_q;
      prio_c_d = prio_c_q;
      prio_d_d = prio_d_q;
      prio_ext_d = prio_ext_q;
      if (prio_wr_i) begin
         case (prio_sel_i)
            irq_prio_pkg::SEL_A: prio_a_d = prio_wdata_i;
            irq_prio_pkg::SEL_B: prio_b_d = prio_wdata_i & `PRIO_B_MASK;
            irq_prio_pkg::SEL_C: prio_c_d = prio_wdata_i;
            irq_prio_pkg::SEL_D: begin
               if (!BASE_VARIANT) begin
                  prio_d_d = prio_wdata_i;
               end
            end
            irq_prio_pkg::SEL_EXT: prio_ext_d = prio_wdata_i;
            default: prio_a_d = prio_a_q;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         prio_a_q <= `PRIO_A_RST;
         prio_b_q <= `PRIO_B_RST;
         prio_c_q <= `PRIO_C_RST;
         prio_d_q <= `PRIO_D_RST;
         prio_ext_q <= `PRIO_EXT_RST;
      end else begin
         prio_a_q <= prio_a_d;
         prio_b_q <= prio_b_d;
         prio_c_q <= prio_c_d;
         prio_d_q <= prio_d_d;
         prio_ext_q <= prio_ext_d;
      end
   end

   // pins are asynchronous; two flops before anything looks at them.
   // the idle value is all ones so reset does not fake a request
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pin_meta_q <= `PIN_IDLE;
         pin_sync_q <= `PIN_IDLE;
      end else begin
         pin_meta_q <= encoded_request_pins_n_i;
         pin_sync_q <= pin_meta_q;
      end
   end

   // build the source table in default order, highest first
   always_comb begin
      src_code = CODES;
      src_lvl = '0;
      src_lvl[0] = ent(nmi_req_i, `LVL_NMI);
      if (!pin_mode_select_i) begin
         // encoded level: ~v equals 15 - v, and all ones gives level 0
         src_lvl[1] = {1'b0, ~pin_sync_q};
         src_code[1] = `EV_PIN_BASE + {3'b000, pin_sync_q, 5'b00000};
      end else begin
         src_lvl[2] = ent(!pin_sync_q[0], fld(prio_d_q, `FLD_15_12));
         src_lvl[3] = ent(!pin_sync_q[1], fld(prio_d_q, `FLD_11_8));
         src_lvl[4] = ent(!pin_sync_q[2], fld(prio_d_q, `FLD_7_4));
         src_lvl[5] = ent(!pin_sync_q[3], fld(prio_d_q, `FLD_3_0));
      end
      src_lvl[6] = ent(periph_irq_i.debug_iface, fld(prio_c_q, `FLD_3_0));
      src_lvl[7] = ent(periph_irq_i.port_irq, fld(prio_c_q, `FLD_15_12));
      for (int i = 0; i < 8; i++) begin
         src_lvl[8+i] = ent(periph_irq_i.dma_done_irq[i], fld(prio_c_q, `FLD_11_8));
      end
      src_lvl[16] = ent(periph_irq_i.dma_addr_fault_irq, fld(prio_c_q, `FLD_11_8));
      // timers 3 and 4 rank ahead of 0 to 2 when levels tie
      src_lvl[17] = ent(periph_irq_i.timer_underflow_irq[3], fld(prio_ext_q, `FLD_11_8));
      src_lvl[18] = ent(periph_irq_i.timer_underflow_irq[4], fld(prio_ext_q, `FLD_15_12));
      src_lvl[19] = ent(periph_irq_i.timer_underflow_irq[0], fld(prio_a_q, `FLD_15_12));
      src_lvl[20] = ent(periph_irq_i.timer_underflow_irq[1], fld(prio_a_q, `FLD_11_8));
      src_lvl[21] = ent(periph_irq_i.timer_underflow_irq[2], fld(prio_a_q, `FLD_7_4));
      src_lvl[22] = ent(periph_irq_i.timer_capture_irq, fld(prio_a_q, `FLD_7_4));
      src_lvl[23] = ent(periph_irq_i.alarm_irq, fld(prio_a_q, `FLD_3_0));
      src_lvl[24] = ent(periph_irq_i.periodic_irq, fld(prio_a_q, `FLD_3_0));
      src_lvl[25] = ent(periph_irq_i.carry_irq, fld(prio_a_q, `FLD_3_0));
      src_lvl[26] = ent(periph_irq_i.sci_rx_error_irq, fld(prio_b_q, `FLD_7_4));
      src_lvl[27] = ent(periph_irq_i.sci_rx_full_irq, fld(prio_b_q, `FLD_7_4));
      src_lvl[28] = ent(periph_irq_i.sci_tx_empty_irq, fld(prio_b_q, `FLD_7_4));
      src_lvl[29] = ent(periph_irq_i.sci_tx_end_irq, fld(prio_b_q, `FLD_7_4));
      src_lvl[30] = ent(periph_irq_i.fifo_serial_unit_rx_error_irq, fld(prio_c_q, `FLD_7_4));
      src_lvl[31] = ent(periph_irq_i.fifo_serial_unit_rx_full_irq, fld(prio_c_q, `FLD_7_4));
      src_lvl[32] = ent(periph_irq_i.fifo_serial_unit_line_break_irq, fld(prio_c_q, `FLD_7_4));
      src_lvl[33] = ent(periph_irq_i.fifo_serial_unit_tx_empty_irq, fld(prio_c_q, `FLD_7_4));
      src_lvl[34] = ent(periph_irq_i.interval_irq, fld(prio_b_q, `FLD_15_12));
      src_lvl[35] = ent(periph_irq_i.refresh_match_irq, fld(prio_b_q, `FLD_11_8));
      src_lvl[36] = ent(periph_irq_i.refresh_overflow_irq, fld(prio_b_q, `FLD_11_8));
   end

   // table order is the tie-break, so the picker needs no extra rank input
   level_pick #(
      .N(NSRC),
      .LW(5),
      .CW(12)
   ) u_pick (
      .lvl_i(src_lvl),
      .code_i(src_code),
      .valid_o(pick_valid),
      .lvl_o(pick_lvl),
      .code_o(pick_code)
   );

   // the winner is re-registered every cycle, one cycle behind nmi and unit requests and three behind the pins
   always_comb begin
      result_d.pending = pick_valid;
      result_d.level = pick_lvl;
      result_d.code = pick_valid ? pick_code : 12'h000;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         result_q <= '0;
      end else begin
         result_q <= result_d;
      end
   end

   assign priority_reg_a_o = prio_a_q;
   assign priority_reg_b_o = prio_b_q;
   assign priority_reg_c_o = prio_c_q;
   assign priority_reg_d_o = prio_d_q;
   assign extended_priority_reg_o = prio_ext_q;
   assign result_o = result_q;

endmodule

`default_nettype wire

//--- verif/irq_checker.sv
`timescale 1ns/100ps
`default_nettype none
module irq_checker (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic nmi_req_i,
   input wire logic [3:0] encoded_request_pins_n_i,
   input wire logic pin_mode_select_i,
   input wire irq_prio_pkg::periph_irq_t periph_irq_i,
   input wire logic prio_wr_i,
   input wire irq_prio_pkg::prio_sel_t prio_sel_i,
   input wire logic [15:0] prio_wdata_i,
   input wire logic [15:0] priority_reg_a_o,
   input wire logic [15:0] priority_reg_b_o,
   input wire logic [15:0] priority_reg_d_o,
   input wire irq_prio_pkg::irq_result_t result_o
);
   // one clock domain, so clocking and reset are shared by all checks
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // registers hold their reset values at the first edge out of reset
   reset_vals_a: assert property ($rose(rst_n_i) |-> priority_reg_d_o == 16'hda74 &&
      priority_reg_a_o == 16'h0000 && priority_reg_b_o == 16'h0000)
      else $error("priority registers not at reset values");
   write_load_a: assert property (prio_wr_i && prio_sel_i == irq_prio_pkg::SEL_A
      |=> priority_reg_a_o == $past(prio_wdata_i)) else $error("write to a not loaded");
   hold_idle_a: assert property (!prio_wr_i |=> $stable(priority_reg_a_o))
      else $error("register a changed without a write");
   resv_zero_a: assert property (priority_reg_b_o[3:0] == 4'h0)
      else $error("reserved bits of b not zero");
   nmi_top_a: assert property (nmi_req_i |=> result_o.level == 5'h10 &&
      result_o.code == 12'h1c0) else $error("nmi not reported on top");
   pend_level_a: assert property (result_o.pending == (result_o.level != 5'h00))
      else $error("pending and level disagree");
   idle_code_a: assert property (!result_o.pending |-> result_o.code == 12'h000)
      else $error("code nonzero while idle");
   quiet_none_a: assert property ((!nmi_req_i && periph_irq_i == '0 &&
      encoded_request_pins_n_i == 4'hf) [*3] |=> !result_o.pending)
      else $error("pending with no request");
   pin_top_a: assert property ((!nmi_req_i && !pin_mode_select_i &&
      encoded_request_pins_n_i == 4'h0) [*3] |=> result_o.level == 5'h0f &&
      result_o.code == 12'h200) else $error("encoded pins zero not level 15");
   cover property (nmi_req_i && result_o.pending);
   cover property (result_o.pending && result_o.level == 5'h0f);
   cover property (prio_wr_i && prio_sel_i == irq_prio_pkg::SEL_EXT);
endmodule
bind interrupt_priority_resolver irq_checker u_irq_checker (.clk_i(clk_i),
   .rst_n_i(rst_n_i), .nmi_req_i(nmi_req_i), .pin_mode_select_i(pin_mode_select_i),
   .encoded_request_pins_n_i(encoded_request_pins_n_i), .periph_irq_i(periph_irq_i),
   .prio_wr_i(prio_wr_i), .prio_sel_i(prio_sel_i), .prio_wdata_i(prio_wdata_i),
   .priority_reg_a_o(priority_reg_a_o), .priority_reg_b_o(priority_reg_b_o),
   .priority_reg_d_o(priority_reg_d_o), .result_o(result_o));
`default_nettype wire

//--- verif/unit_req_model.sv
`timescale 1ns/100ps
`default_nettype none
module unit_req_model (
   input wire logic clk_i,
   input wire irq_prio_pkg::periph_irq_t req_i,
   output irq_prio_pkg::periph_irq_t irq_o
);
   // units raise requests from their own flops, one edge after the event
   always_ff @(posedge clk_i) begin
      irq_o <= req_i;
   end
endmodule
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic nmi = 1'b0;
   logic mode = 1'b0;
   logic wr = 1'b0;
   logic [3:0] pins = 4'hf;
   logic [15:0] wd = 16'h0000;
   irq_prio_pkg::prio_sel_t sel = irq_prio_pkg::SEL_A;
   irq_prio_pkg::periph_irq_t req = '0;
   irq_prio_pkg::periph_irq_t irq;
   irq_prio_pkg::irq_result_t res;
   logic [15:0] ra, rb, rc, rd, rx;
   int err_total = 0;
   int checks_done = 0;
   // struct bit of each unit source, in tie-break order, and its code
   localparam int BITS [31] = '{30, 29, 21, 22, 23, 24, 25, 26, 27, 28, 20, 18, 19, 15, 16,
      17, 14, 13, 12, 11, 10, 9, 8, 7, 6, 5, 4, 3, 2, 1, 0};
   localparam logic [11:0] CODES [31] = '{12'h600, 12'h620, 12'h640, 12'h660, 12'h680,
      12'h6a0, 12'h780, 12'h7a0, 12'h7c0, 12'h7e0, 12'h6c0, 12'hb00, 12'hb80, 12'h400,
      12'h420, 12'h440, 12'h460, 12'h480, 12'h4a0, 12'h4c0, 12'h4e0, 12'h500, 12'h520,
      12'h540, 12'h700, 12'h720, 12'h740, 12'h760, 12'h560, 12'h580, 12'h5a0};
   always #10 clk_i = ~clk_i;
   unit_req_model u_unit_req_model (.clk_i(clk_i), .req_i(req), .irq_o(irq));
   interrupt_priority_resolver u_interrupt_priority_resolver (.clk_i(clk_i),
      .rst_n_i(rst_n_i), .nmi_req_i(nmi), .encoded_request_pins_n_i(pins),
      .pin_mode_select_i(mode), .periph_irq_i(irq), .prio_wr_i(wr), .prio_sel_i(sel),
      .prio_wdata_i(wd), .priority_reg_a_o(ra), .priority_reg_b_o(rb),
      .priority_reg_c_o(rc), .priority_reg_d_o(rd), .extended_priority_reg_o(rx),
      .result_o(res));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // inputs always move 1 ns after the edge, away from sampling
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // one write, then an idle edge so back to back writes never share a step;
   // the bench plays software that has already blocked cpu interrupts here
   task automatic wreg(input irq_prio_pkg::prio_sel_t s, input logic [15:0] d);
      sel = s;
      wd = d;
      wr = 1'b1;
      cyc(1);
      wr = 1'b0;
      cyc(1);
   endtask
   task automatic t_reset();
      chk(ra, 16'h0000);
      chk(rb, 16'h0000);
      chk(rc, 16'h0000);
      chk(rx, 16'h0000);
      chk(rd, 16'hda74);
      chk(res, 18'h0);
   endtask
   task automatic t_nmi();
      nmi = 1'b1;
      pins = 4'h0;
      cyc(4);
      chk(res, {1'b1, 5'h10, 12'h1c0});
      nmi = 1'b0;
      pins = 4'hf;
      cyc(4);
   endtask
   task automatic t_enc();
      for (int p = 0; p < 15; p++) begin
         pins = 4'(p);
         cyc(4);
         chk(res, {1'b1, 5'(15 - p), 12'h200 + 12'(p * 32)});
      end
      pins = 4'hf;
      cyc(4);
      chk(res, 18'h0);
   endtask
   task automatic t_indep();
      int lv [4] = '{13, 10, 7, 4};
      logic [11:0] cd [4] = '{12'h240, 12'h2a0, 12'h300, 12'h360};
      mode = 1'b1;
      for (int i = 0; i < 4; i++) begin
         pins = ~(4'h1 << i);
         cyc(4);
         chk(res, {1'b1, 5'(lv[i]), cd[i]});
      end
      pins = 4'h0;
      cyc(4);
      chk(res, {1'b1, 5'd13, 12'h240});
      wreg(irq_prio_pkg::SEL_D, 16'h1239);
      chk(rd, 16'h1239);
      chk(res, {1'b1, 5'd9, 12'h360});
      mode = 1'b0;
      pins = 4'hf;
      cyc(4);
   endtask
   task automatic t_mask();
      req.alarm_irq = 1'b1;
      cyc(3);
      chk(res, 18'h0);
      wreg(irq_prio_pkg::SEL_A, 16'h0005);
      chk(res, {1'b1, 5'd5, 12'h480});
      req.interval_irq = 1'b1;
      wreg(irq_prio_pkg::SEL_B, 16'h6000);
      chk(res, {1'b1, 5'd6, 12'h560});
      req = '0;
   endtask
   // every unit at level 15; drain the winner one by one
   task automatic t_ties();
      wreg(irq_prio_pkg::SEL_A, 16'hffff);
      wreg(irq_prio_pkg::SEL_B, 16'hffff);
      wreg(irq_prio_pkg::SEL_C, 16'hffff);
      wreg(irq_prio_pkg::SEL_EXT, 16'hffff);
      chk(rb, 16'hfff0);
      chk(rx, 16'hffff);
      req = '1;
      cyc(3);
      for (int i = 0; i < 31; i++) begin
         chk(res, {1'b1, 5'h0f, CODES[i]});
         req[BITS[i]] = 1'b0;
         cyc(3);
      end
      chk(res, 18'h0);
   endtask
   // reset in mid-run must reload every register and hold off a standing request
   task automatic t_rerun();
      nmi = 1'b1;
      rst_n_i = 1'b0;
      cyc(2);
      rst_n_i = 1'b1;
      chk(ra, 16'h0000);
      chk(rb, 16'h0000);
      chk(rc, 16'h0000);
      chk(rx, 16'h0000);
      chk(rd, 16'hda74);
      chk(res, 18'h0);
      cyc(1);
      chk(res, {1'b1, 5'h10, 12'h1c0});
      nmi = 1'b0;
      cyc(2);
      chk(res, 18'h0);
   endtask
   task automatic results();
      $display("checks_done=%0d err_total=%0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      cyc(5);
      rst_n_i = 1'b1;
      cyc(1);
      t_reset();
      t_nmi();
      t_enc();
      t_indep();
      t_mask();
      t_ties();
      t_rerun();
      results();
   end
   // the run needs well under 1000 cycles
   initial begin
      #100000;
      err_total++;
      results();
   end
endmodule
`default_nettype wire
